//--- design/msk_packet_modem.sv
// Purpose: MSK/FFSK modem with frame packetising
// Assumes: rxSignal is the hard-limited receive tone, txTone drives the audio path
// Notes: data block interleave and scrambling are handled elsewhere
`timescale 1ns/1ps
`include "msk_map.svh"

// Operation
// - receive both rates, detect rate automatically
// - fixed rate ignores tones of other rate
// - sixteen-bit receive words flagged when ready
// - unread receive word overwritten; host reads promptly
// - programmable frame sync, reset value CB23
// - flag on sync or after head
// - demodulator off stops sync search
// - one sync only until mode re-enabled
// - corrupt head resumes sync search
// - keep demodulating until host disables or a sized block ends
// - flag last block of sized packets
// - own bit clock, words sent msb first
// - tone cycles per bit per rate
// - bit sync, frame sync, four-byte head
// - last-data flag adds hang bit to unsized data blocks, then stop
// - sized blocks end with 16/32-bit checksum
// - four check bits per head byte
// - address match or 40 flags valid head
// - head 48 coded bits, readable in data registers
// - third byte is size only when sized
// - recovered bit clock stays internal
// - rate lock holds until host leaves receive mode
module msk_packet_modem #(
  parameter int HALF1200 = `MSK_CLK_HZ / (2 * `MSK_TONE1200_HZ),
  parameter int HALF1800 = `MSK_CLK_HZ / (2 * `MSK_TONE1800_HZ),
  parameter int HALF2400 = `MSK_CLK_HZ / (2 * `MSK_TONE2400_HZ)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // mode control
  input wire msk_pkg::msk_mode_e modemMode,
  input wire msk_pkg::msk_rate_e rateSel,
  input wire logic headFirst,
  input wire logic [7:0] stationMatchAddress,
  input wire logic frameSyncWrite,
  input wire logic [15:0] frameSyncData,
  // receive
  input wire logic rxSignal,
  output logic [15:0] rxData1,
  output logic [15:0] rxData2,
  output logic rxReady,
  output logic syncFound,
  output logic headValid,
  output logic lastBlock,
  output msk_pkg::msk_lock_e rxBaudLock,
  // transmit settings
  input wire logic [15:0] bitSyncPattern,
  input wire logic [7:0] txAddress,
  input wire logic [2:0] txFormat,
  input wire logic [7:0] txSizeUser,
  input wire logic txLastData,
  input wire logic txRate2400,
  // transmit word stream
  input wire logic [15:0] txWord,
  input wire logic txWordValid,
  output logic txWordReady,
  // modulator
  output logic txTone,
  output logic txActive,
  output logic txDone
);
  import msk_pkg::*;

  // ==========================================================
  // constants
  localparam logic [14:0] H12 = 15'(HALF1200);
  localparam logic [14:0] H18 = 15'(HALF1800);
  localparam logic [14:0] H24 = 15'(HALF2400);
  localparam logic [14:0] SPLIT_LM = 15'((HALF1200 + HALF1800) / 2);
  localparam logic [14:0] SPLIT_MS = 15'((HALF1800 + HALF2400) / 2);
  localparam logic [14:0] MIN_S = 15'(HALF2400 / 2);
  localparam logic [7:0] FM3 = `MSK_FEC_M3;
  localparam logic [7:0] FM2 = `MSK_FEC_M2;
  localparam logic [7:0] FM1 = `MSK_FEC_M1;
  localparam logic [7:0] FM0 = `MSK_FEC_M0;

  // ==========================================================
  // coding helpers
  // four check bits of one byte
  function automatic logic [3:0] fecBits(input logic [7:0] b);
    return {^(b & FM3), ^(b & FM2), ^(b & FM1), ^(b & FM0)};
  endfunction : fecBits

  // single-bit correction of a 12-bit coded byte
  function automatic logic [7:0] fecFix(input logic [11:0] w);
    logic [3:0] syn;
    logic [7:0] fixed;
    syn = w[3:0] ^ fecBits(w[11:4]);
    fixed = w[11:4];
    for (int k = 0; k < 8; k++) begin
      if (syn == {FM3[k], FM2[k], FM1[k], FM0[k]}) fixed[k] = ~w[4+k];
    end
    return fixed;
  endfunction : fecFix

  // head checksum over three bytes, msb first
  function automatic logic [7:0] crc8(input logic [23:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? `MSK_CRC8_POLY : 8'h00);
    end
    return c;
  endfunction : crc8

  // block checksum step, left-aligned in 32 bits
  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b,
                                          input logic [31:0] poly);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ b[i]) ? poly : 32'h0000_0000);
    end
    return r;
  endfunction : crcByte

  // ==========================================================
  // state and working signals
  msk_state_s q; // registered state
  msk_state_s d; // next state
  msk_cls_e cls; // class of last half period
  logic newBit; // one recovered bit this cycle
  logic bitVal; // its value
  logic [15:0] shNext; // receive shifter with new bit
  logic [47:0] headNext; // head shifter with new bit
  logic [7:0] hA, hF, hS, hC; // corrected head bytes
  logic [8:0] sizeBytes; // data plus checksum bytes
  logic [11:0] target; // coded bits of a sized block
  logic needBit; // tone engine is idle
  logic txBit; // bit being started
  logic [7:0] hb; // head byte to send
  logic [15:0] popW; // oldest transmit word
  logic push; // transmit word taken
  logic popWord; // transmit word consumed
  logic txSized; // transmit block carries size
  logic [31:0] crcPoly; // selected block checksum

  // ==========================================================
  // next-state logic
  always_comb begin
    d = q;
    d.evReady = 1'b0;
    d.evSync = 1'b0;
    d.evHead = 1'b0;
    d.evLast = 1'b0;
    d.evDone = 1'b0;
    cls = CLS_NONE;
    newBit = 1'b0;
    bitVal = 1'b0;
    txBit = 1'b0;
    hb = 8'h00;
    popWord = 1'b0;
    push = txWordValid && (q.fifoN != 2'h2);
    popW = q.fifoMem[q.rdP];
    txSized = (txFormat == 3'h4) || (txFormat == 3'h5);
    crcPoly = (txSizeUser <= `MSK_SHORT_CRC_MAX) ? `MSK_CRC16_POLY : `MSK_CRC32_POLY;
    // three-stage input synchroniser
    d.rxS1 = rxSignal;
    d.rxS2 = q.rxS1;
    d.rxS3 = q.rxS2;
    if (q.rxHalf != 15'h7FFF) d.rxHalf = q.rxHalf + 15'h0001;
    // classify a settled edge by half-period length; glitches are dropped
    if ((q.rxS2 == q.rxS3) && (q.rxS3 != q.rxLvl)) begin
      if (q.rxHalf >= SPLIT_LM) cls = CLS_L;
      else if (q.rxHalf >= SPLIT_MS) cls = CLS_M;
      else if (q.rxHalf >= MIN_S) cls = CLS_S;
      if (cls != CLS_NONE) begin
        d.rxLvl = q.rxS3;
        d.rxHalf = 15'h0000;
      end
    end
    // rate lock and bit recovery; the bit timing never leaves the block
    if (q.rxSt != RX_IDLE) begin
      if (q.lock == LOCK_NONE && cls == CLS_M) d.lock = LOCK_1200;
      if (q.lock == LOCK_NONE && cls == CLS_S) d.lock = LOCK_2400;
      case (cls)
        // low tone: two halves a one at 1200, one half at 2400
        CLS_L: begin
          d.zeroN = 2'h0;
          if (q.lock == LOCK_2400 || (q.lock == LOCK_1200 && q.longN)) begin
            newBit = 1'b1;
            bitVal = 1'b1;
            d.longN = 1'b0;
          end else if (q.lock == LOCK_1200) begin
            d.longN = 1'b1;
          end
        end
        // 1800 Hz: three halves make a zero, dropped under 2400 lock
        CLS_M: begin
          d.longN = 1'b0;
          d.zeroN = 2'h0;
          if (q.lock == LOCK_1200) begin
            if (q.zeroN == 2'h2) newBit = 1'b1;
            else d.zeroN = q.zeroN + 2'h1;
          end
        end
        // 2400 Hz: two halves make a zero, dropped under 1200 lock
        CLS_S: begin
          d.longN = 1'b0;
          d.zeroN = 2'h0;
          if (q.lock == LOCK_2400) begin
            if (q.zeroN == 2'h1) newBit = 1'b1;
            else d.zeroN = q.zeroN + 2'h1;
          end
        end
        default: ;
      endcase
    end
    // receive framing
    shNext = {q.rxSh[14:0], bitVal};
    headNext = {q.headSh[46:0], bitVal};
    hA = fecFix(headNext[47:36]);
    hF = fecFix(headNext[35:24]);
    hS = fecFix(headNext[23:12]);
    hC = fecFix(headNext[11:0]);
    sizeBytes = {1'b0, q.size} + ((q.size <= `MSK_SHORT_CRC_MAX) ? 9'h002 : 9'h004);
    target = {sizeBytes, 3'b000} + {1'b0, sizeBytes, 2'b00};
    if (modemMode != MODE_RX) begin
      d.rxSt = RX_IDLE;
      d.lock = LOCK_NONE;
    end else begin
      case (q.rxSt)
        // enable: preset the lock from the fixed rate, if any
        RX_IDLE: begin
          d.rxSt = RX_HUNT;
          d.longN = 1'b0;
          d.zeroN = 2'h0;
          if (rateSel == RATE_1200) d.lock = LOCK_1200;
          else if (rateSel == RATE_2400) d.lock = LOCK_2400;
          else d.lock = LOCK_NONE;
        end
        // sync search
        RX_HUNT: begin
          if (newBit) begin
            d.rxSh = shNext;
            if (shNext == q.frameSync) begin
              d.evSync = !headFirst;
              d.rxSt = headFirst ? RX_HEAD : RX_DATA;
              d.rxCnt = 6'h00;
              d.dataBits = 12'h000;
              d.sized = 1'b0;
            end
          end
        end
        // 48 coded head bits after the sync
        RX_HEAD: begin
          if (newBit) begin
            d.headSh = headNext;
            d.rxCnt = q.rxCnt + 6'h01;
            if (q.rxCnt == `MSK_HEAD_LAST) begin
              d.rxCnt = 6'h00;
              if (crc8({hA, hF, hS}) == hC &&
                  (hA == stationMatchAddress || hA == `MSK_ADDR_ALL)) begin
                d.rxData1 = {hA, hF};
                d.rxData2 = {hS, hC};
                d.evHead = 1'b1;
                d.size = hS;
                d.sized = (hF[2:0] == 3'h4) || (hF[2:0] == 3'h5);
                d.rxSt = RX_DATA;
              end else begin
                d.rxSt = RX_HUNT;
              end
            end
          end
        end
        // words until the host stops us, or the sized block ends
        RX_DATA: begin
          if (newBit) begin
            d.rxSh = shNext;
            d.rxCnt = q.rxCnt + 6'h01;
            d.dataBits = q.dataBits + 12'h001;
            if (q.sized && (q.dataBits + 12'h001 == target)) begin
              d.rxData1 = shNext;
              d.evReady = 1'b1;
              d.evLast = 1'b1;
              d.rxSt = RX_DONE;
            end else if (q.rxCnt[3:0] == 4'hF) begin
              d.rxData1 = shNext;
              d.evReady = 1'b1;
            end
          end
        end
        // finished, waits for the mode to be cleared
        RX_DONE: ;
        default: d.rxSt = RX_IDLE;
      endcase
    end
    // frame sync pattern load
    if (frameSyncWrite) d.frameSync = frameSyncData;
    // transmit buffer write
    if (push) begin
      d.fifoMem[q.wrP] = txWord;
      d.wrP = ~q.wrP;
    end
    // tone engine: toggles the tone at the end of each half period
    needBit = (q.halves == 2'h0);
    if (!needBit) begin
      if (q.halfCnt == 15'h0000) begin
        d.tone = ~q.tone;
        d.halves = q.halves - 2'h1;
        d.halfCnt = q.halfLen - 15'h0001;
      end else begin
        d.halfCnt = q.halfCnt - 15'h0001;
      end
    end
    // transmit sequencing
    if (modemMode != MODE_TX) begin
      d.txSt = TX_IDLE;
      d.txLeft = 5'h00;
      d.halves = 2'h0;
    end else if (needBit && q.txLeft != 5'h00) begin
      // next bit, msb first, with its tone pattern
      txBit = q.txSh[23];
      d.txSh = {q.txSh[22:0], 1'b0};
      d.txLeft = q.txLeft - 5'h01;
      if (txRate2400) begin
        d.halfLen = txBit ? H12 : H24;
        d.halves = txBit ? 2'h1 : 2'h2;
      end else begin
        d.halfLen = txBit ? H12 : H18;
        d.halves = txBit ? 2'h2 : 2'h3;
      end
      d.halfCnt = d.halfLen - 15'h0001;
    end else if (needBit) begin
      case (q.txSt)
        // start from the settings already loaded
        TX_IDLE: begin
          d.byteCnt = 8'h00;
          d.crc = 32'h0000_0000;
          d.hIdx = 2'h0;
          if (txFormat == 3'h0) begin
            d.txSt = TX_DATA;
          end else begin
            d.txSh = {bitSyncPattern, 8'h00};
            d.txLeft = 5'h10;
            d.txSt = TX_FSYNC;
          end
        end
        TX_FSYNC: begin
          d.txSh = {q.frameSync, 8'h00};
          d.txLeft = 5'h10;
          d.txSt = TX_HEAD;
        end
        // address, format, size or user, checksum; each with check bits
        TX_HEAD: begin
          case (q.hIdx)
            2'h0: hb = txAddress;
            2'h1: hb = {5'h00, txFormat};
            2'h2: hb = txSizeUser;
            default: hb = crc8({txAddress, 5'h00, txFormat, txSizeUser});
          endcase
          d.txSh = {hb, fecBits(hb), 12'h000};
          d.txLeft = 5'h0C;
          d.hIdx = q.hIdx + 2'h1;
          d.crcLeft = (txSizeUser <= `MSK_SHORT_CRC_MAX) ? 3'h2 : 3'h4;
          if (q.hIdx == 2'h3) begin
            if (txFormat == 3'h1) d.txSt = TX_END;
            else if (txSized && txSizeUser == 8'h00) d.txSt = TX_CRC;
            else d.txSt = TX_DATA;
          end
        end
        // words from the buffer; a dry buffer waits, or goes to the hang bit on last data when unsized
        TX_DATA: begin
          if (q.fifoN != 2'h0) begin
            popWord = 1'b1;
            if (txFormat == 3'h0 || txFormat == 3'h2) begin
              d.txSh = {popW, 8'h00};
              d.txLeft = 5'h10;
            end else begin
              d.txSh = {popW[15:8], fecBits(popW[15:8]), popW[7:0], fecBits(popW[7:0])};
              d.txLeft = 5'h18;
            end
            if (txSized) begin
              d.byteCnt = q.byteCnt + 8'h02;
              d.crc = crcByte(crcByte(q.crc, popW[15:8], crcPoly), popW[7:0], crcPoly);
              if ({1'b0, q.byteCnt} + 9'h001 == {1'b0, txSizeUser}) begin
                d.txLeft = 5'h0C;
                d.crc = crcByte(q.crc, popW[15:8], crcPoly);
                d.txSt = TX_CRC;
              end else if ({1'b0, q.byteCnt} + 9'h002 == {1'b0, txSizeUser}) begin
                d.txSt = TX_CRC;
              end
            end
          end else if (txLastData && !txSized) begin
            d.txSt = TX_HANG;
          end
        end
        // block checksum bytes, top first
        TX_CRC: begin
          d.txSh = {q.crc[31:24], fecBits(q.crc[31:24]), 12'h000};
          d.txLeft = 5'h0C;
          d.crc = {q.crc[23:0], 8'h00};
          d.crcLeft = q.crcLeft - 3'h1;
          if (q.crcLeft == 3'h1) d.txSt = TX_END;
        end
        TX_HANG: begin
          d.txSh = {`MSK_HANG_BIT, 23'h00_0000};
          d.txLeft = 5'h01;
          d.txSt = TX_END;
        end
        // last bit has left: flag and stop modulating
        TX_END: begin
          d.evDone = 1'b1;
          d.txSt = TX_STOP;
        end
        TX_STOP: ;
        default: d.txSt = TX_IDLE;
      endcase
    end
    // transmit buffer bookkeeping
    if (popWord) d.rdP = ~q.rdP;
    d.fifoN = q.fifoN + {1'b0, push} - {1'b0, popWord};
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.frameSync <= `MSK_SYNC_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign rxData1 = q.rxData1;
  assign rxData2 = q.rxData2;
  assign rxReady = q.evReady;
  assign syncFound = q.evSync;
  assign headValid = q.evHead;
  assign lastBlock = q.evLast;
  assign rxBaudLock = q.lock;
  assign txWordReady = (q.fifoN != 2'h2);
  assign txTone = q.tone;
  assign txActive = (q.txSt != TX_IDLE) && (q.txSt != TX_STOP);
  assign txDone = q.evDone;
endmodule : msk_packet_modem

//--- design/msk_map.svh
// Purpose: constants of the packet modem
// Assumes: 40 MHz system clock
// Notes: tone counts are derived in the modem from these rates
`ifndef MSK_MAP_SVH
`define MSK_MAP_SVH
// ==========================================================
// timing
`define MSK_CLK_HZ 40000000
`define MSK_TONE1200_HZ 1200
`define MSK_TONE1800_HZ 1800
`define MSK_TONE2400_HZ 2400
// ==========================================================
// frame constants
`define MSK_SYNC_RESET 16'hCB23
`define MSK_ADDR_ALL 8'h40
`define MSK_SHORT_CRC_MAX 8'h10
`define MSK_HANG_BIT 1'b1
`define MSK_HEAD_LAST 6'h2F
`define MSK_CRC8_POLY 8'h9B
`define MSK_CRC16_POLY 32'h1021_0000
`define MSK_CRC32_POLY 32'hDB71_0641
// ==========================================================
// error-correction masks, one per check bit 3..0
`define MSK_FEC_M3 8'hEC
`define MSK_FEC_M2 8'hD3
`define MSK_FEC_M1 8'hBA
`define MSK_FEC_M0 8'h75
`endif

//--- design/msk_pkg.sv
// Purpose: types of the packet modem
// Assumes: nothing
// Notes: all modem state lives in one packed struct
package msk_pkg;
  // ==========================================================
  // modes and states
  typedef enum logic [1:0] {MODE_OFF, MODE_RX, MODE_TX} msk_mode_e;
  typedef enum logic [1:0] {RATE_AUTO, RATE_1200, RATE_2400} msk_rate_e;
  typedef enum logic [1:0] {LOCK_NONE, LOCK_1200, LOCK_2400} msk_lock_e;
  typedef enum logic [1:0] {CLS_NONE, CLS_S, CLS_M, CLS_L} msk_cls_e;
  typedef enum logic [2:0] {RX_IDLE, RX_HUNT, RX_HEAD, RX_DATA, RX_DONE} msk_rx_e;
  typedef enum logic [2:0] {
    TX_IDLE, TX_FSYNC, TX_HEAD, TX_DATA, TX_CRC, TX_HANG, TX_END, TX_STOP
  } msk_tx_e;
  // ==========================================================
  // whole modem state
  typedef struct packed {
    logic rxS1;
    logic rxS2;
    logic rxS3;
    logic rxLvl;
    logic [14:0] rxHalf;
    msk_lock_e lock;
    logic longN;
    logic [1:0] zeroN;
    msk_rx_e rxSt;
    logic [15:0] rxSh;
    logic [47:0] headSh;
    logic [5:0] rxCnt;
    logic [7:0] size;
    logic sized;
    logic [11:0] dataBits;
    logic [15:0] rxData1;
    logic [15:0] rxData2;
    logic evReady;
    logic evSync;
    logic evHead;
    logic evLast;
    logic [15:0] frameSync;
    msk_tx_e txSt;
    logic [23:0] txSh;
    logic [4:0] txLeft;
    logic [1:0] hIdx;
    logic [7:0] byteCnt;
    logic [31:0] crc;
    logic [2:0] crcLeft;
    logic [1:0][15:0] fifoMem;
    logic wrP;
    logic rdP;
    logic [1:0] fifoN;
    logic [1:0] halves;
    logic [14:0] halfCnt;
    logic [14:0] halfLen;
    logic tone;
    logic evDone;
  } msk_state_s;
endpackage : msk_pkg

//--- testbench/msk_packet_modem_sva.sv
// Purpose: port checker for the packet modem
// Assumes: one clock, nrst async active low
// Notes: bound onto the modem top
`timescale 1ns/1ps
module msk_packet_modem_sva #(
  parameter int HALF2400 = 8333
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire msk_pkg::msk_mode_e modemMode,
  input wire msk_pkg::msk_rate_e rateSel,
  input wire logic headFirst,
  // receive flags
  input wire logic rxReady,
  input wire logic syncFound,
  input wire logic headValid,
  input wire logic lastBlock,
  input wire msk_pkg::msk_lock_e rxBaudLock,
  // transmit
  input wire logic txWordReady,
  input wire logic txTone,
  input wire logic txActive,
  input wire logic txDone
);
  import msk_pkg::*;
  logic syncSeen_q; // sync already flagged this session
  logic [15:0] toneGap_q; // cycles since last tone edge
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // helper state: one sync per session, tone edge spacing
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      syncSeen_q <= 1'b0;
      toneGap_q <= 16'h0000;
    end else begin
      syncSeen_q <= (modemMode == MODE_RX) && (syncSeen_q || syncFound);
      toneGap_q <= $changed(txTone) ? 16'h0000 : toneGap_q + {15'h0000, ~&toneGap_q};
    end
  end
  // ==========================================================
  // properties
  a_reset_idle: assert property ($rose(nrst) |-> txWordReady && !txActive)
    else $error("bad state after reset");
  a_sync_gate: assert property (syncFound |-> !headFirst ##1 !syncFound)
    else $error("sync flag wrong");
  a_sync_once: assert property (syncFound |-> !syncSeen_q)
    else $error("second sync in session");
  a_head_gate: assert property (headValid |-> headFirst && !syncFound)
    else $error("head flag without head mode");
  a_last_ready: assert property (lastBlock |-> rxReady)
    else $error("last block without word");
  a_lock_hold: assert property (modemMode == MODE_RX && $past(modemMode) == MODE_RX
    && $past(rxBaudLock) != LOCK_NONE |-> $stable(rxBaudLock))
    else $error("rate lock lost");
  a_fixed_rate: assert property (rxBaudLock == LOCK_1200 |-> rateSel != RATE_2400)
    else $error("locked to excluded rate");
  a_tx_abort: assert property ((modemMode != MODE_TX)[*2] |-> !txActive)
    else $error("modulator runs outside tx");
  a_tone_still: assert property ((!txActive)[*2] |-> $stable(txTone))
    else $error("tone moves while idle");
  a_done_stop: assert property (txDone |-> ##[0:1] !txActive)
    else $error("no stop after done");
  a_half_min: assert property ($changed(txTone) |-> toneGap_q >= HALF2400 - 1)
    else $error("tone half too short");
endmodule : msk_packet_modem_sva

bind msk_packet_modem msk_packet_modem_sva #(.HALF2400(HALF2400)) i_msk_packet_modem_sva (
  .clk_sys, .nrst, .modemMode, .rateSel, .headFirst, .rxReady, .syncFound, .headValid,
  .lastBlock, .rxBaudLock, .txWordReady, .txTone, .txActive, .txDone
);

//--- testbench/msk_tone_src.sv
// Purpose: far-end tone source feeding the receiver
// Assumes: 25 ns clock period for half lengths
// Notes: line stands still between frames
`timescale 1ns/1ps
module msk_tone_src #(
  parameter int H12 = 60,
  parameter int H18 = 40,
  parameter int H24 = 30
) (
  // audio line
  output logic rxSignal
);
  initial rxSignal = 1'b0;
  // one half period, line flips at its end
  task automatic half(input int n);
    #(n * 25) rxSignal = ~rxSignal;
  endtask : half
  // n bits msb first, fast selects 2400 baud
  task automatic send(input logic [31:0] v, input int n, input logic fast);
    for (int i = n - 1; i >= 0; i--) begin
      if (v[i]) begin
        half(H12);
        if (!fast) half(H12);
      end else begin
        half(fast ? H24 : H18);
        half(fast ? H24 : H18);
        if (!fast) half(H18);
      end
    end
  endtask : send
endmodule : msk_tone_src

//--- testbench/msk_ffsk_packet_modem_bench.sv
// Purpose: self-checking bench of the packet modem
// Assumes: shortened tone half lengths 60/40/30
// Notes: expected results queued, monitors compare
`timescale 1ns/1ps
module msk_ffsk_packet_modem_bench;
  import msk_pkg::*;
  logic clk_sys = 0, nrst = 0, headFirst = 0, frameSyncWrite = 0;
  logic txLastData = 0, txRate2400 = 0, txWordValid = 0, rxSignal;
  msk_mode_e modemMode = MODE_OFF;
  msk_rate_e rateSel = RATE_AUTO;
  msk_lock_e rxBaudLock;
  logic [15:0] txWord = 0, bitSyncPattern = 0, rxData1, rxData2;
  logic [7:0] txAddress = 0, txSizeUser = 0;
  logic [2:0] txFormat = 0;
  logic rxReady, syncFound, headValid, lastBlock, txWordReady, txTone, txActive, txDone;
  logic expBits[$]; // expected air bits
  logic [15:0] expWords[$]; // expected receive words
  int mismatches = 0, n_checks = 0, nSync = 0, seed = 32'h9c1c9479, lg = 0, sh = 0, len;
  time tLast = 0;
  msk_packet_modem #(.HALF1200(60), .HALF1800(40), .HALF2400(30)) i_msk_packet_modem (
    .clk_sys, .nrst, .modemMode, .rateSel, .headFirst, .stationMatchAddress(txAddress),
    .frameSyncWrite, .frameSyncData(txWord), .rxSignal, .rxData1, .rxData2, .rxReady,
    .syncFound, .headValid, .lastBlock, .rxBaudLock, .bitSyncPattern, .txAddress, .txFormat,
    .txSizeUser, .txLastData, .txRate2400, .txWord, .txWordValid, .txWordReady, .txTone,
    .txActive, .txDone
  );
  msk_tone_src #(.H12(60), .H18(40), .H24(30)) i_msk_tone_src (.rxSignal);
  always #12.5 clk_sys = ~clk_sys;
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (e !== s) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic pushb(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) expBits.push_back(v[i]);
  endtask : pushb
  function automatic logic [11:0] fec(input logic [7:0] b);
    return {b, ^(b & 8'hEC), ^(b & 8'hD3), ^(b & 8'hBA), ^(b & 8'h75)};
  endfunction : fec
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h9B : 8'h00);
    return c;
  endfunction : crc8
  // offers one word, held until taken
  task automatic put_word(input logic [15:0] w);
    txWord = w;
    txWordValid = 1'b1;
    // ready is settled at the falling edge; the next rising edge takes the word
    while (txWordReady !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask : put_word
  // ==========================================================
  // monitors: tone edges to bits, receive words, sync count
  task automatic got_bit(input logic b);
    chk("txBit", expBits.size() ? expBits.pop_front() : 1'bx, b);
  endtask : got_bit
  always @(posedge txActive) begin
    tLast = $time;
    lg = 0;
    sh = 0;
  end
  always @(txTone) if (nrst && tLast != 0) begin
    len = ($time - tLast) / 25;
    tLast = $time;
    if (len > 50) begin
      lg++;
      if (txRate2400 || lg == 2) begin
        got_bit(1'b1);
        lg = 0;
      end
    end else if (++sh == (txRate2400 ? 2 : 3)) begin
      got_bit(1'b0);
      sh = 0;
    end
  end
  always @(posedge clk_sys) if (nrst && rxReady === 1'b1)
    chk("rxData1", expWords.size() ? expWords.pop_front() : 16'hxxxx, rxData1);
  always @(posedge clk_sys) if (nrst && syncFound === 1'b1) nSync++;
  // ==========================================================
  // transmit: format 0 words plus hang bit, or format 1 head
  task automatic tx_run(input logic [2:0] fmt, input logic f);
    logic [15:0] w0, w1;
    logic [7:0] a;
    int n;
    w0 = $random(seed);
    w1 = $random(seed);
    a = $random(seed);
    modemMode = MODE_OFF;
    txFormat = fmt;
    txRate2400 = f;
    txAddress = a;
    txSizeUser = w0[7:0];
    bitSyncPattern = w1;
    txLastData = 1'b0;
    tick(4);
    if (fmt == 3'd1) begin
      pushb(w1, 16);
      pushb(32'h0000_CB23, 16);
      pushb(fec(a), 12);
      pushb(fec({5'h00, fmt}), 12);
      pushb(fec(w0[7:0]), 12);
      pushb(fec(crc8({a, 5'h00, fmt, w0[7:0]})), 12);
    end else begin
      put_word(w0);
      put_word(w1);
      txWordValid = 1'b0;
      tick(1);
      chk("txFull", 0, txWordReady);
      pushb({w0, w1}, 32);
      pushb(1, 1);
      txLastData = 1'b1;
    end
    modemMode = MODE_TX;
    for (n = 0; n < 30000 && txDone !== 1'b1; n++) @(posedge clk_sys);
    chk("txDone", 1, n < 30000);
    tick(4);
    chk("bitsLeft", 0, expBits.size());
    $display("test tx format %0d rate %0d done", fmt, f);
  endtask : tx_run
  // ==========================================================
  // receive: preamble, sync, word, sync again taken as data
  task automatic rx_run(input msk_rate_e rs, input logic f, input logic hit);
    logic [15:0] w;
    w = $random(seed);
    modemMode = MODE_OFF;
    txWord = 16'hCB23;
    frameSyncWrite = 1'b1;
    tick(1);
    frameSyncWrite = 1'b0;
    tick(8);
    chk("lockOff", LOCK_NONE, rxBaudLock);
    rateSel = rs;
    nSync = 0;
    modemMode = MODE_RX;
    tick(4);
    if (hit) expWords.push_back(w);
    if (hit) expWords.push_back(16'hCB23);
    i_msk_tone_src.send(32'h0000_AAAA, 16, f);
    i_msk_tone_src.send(32'h0000_CB23, 16, f);
    i_msk_tone_src.send(w, 16, f);
    i_msk_tone_src.send(32'h0000_CB23, 16, f);
    tick(10);
    chk("syncCount", hit, nSync);
    chk("wordsLeft", 0, expWords.size());
    if (hit) chk("lock", f ? LOCK_2400 : LOCK_1200, rxBaudLock);
    else chk("lock1200", 0, rxBaudLock === LOCK_1200);
    $display("test rx rate %0d fast %0d done", rs, f);
  endtask : rx_run
  // ==========================================================
  // verdict and watchdog
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    #2500000;
    mismatches++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (10) @(negedge clk_sys);
    chk("readyRst", 1, txWordReady);
    nrst = 1'b1;
    tx_run(3'd0, 1'b0);
    tx_run(3'd0, 1'b1);
    tx_run(3'd1, 1'b1);
    rx_run(RATE_AUTO, 1'b0, 1'b1);
    rx_run(RATE_AUTO, 1'b1, 1'b1);
    rx_run(RATE_2400, 1'b0, 1'b0);
    finish_test();
  end
endmodule : msk_ffsk_packet_modem_bench
